// >>> ebp_pkg.sv
// constants, types and state layout of the byte programmer
// assumes: one 40 MHz clock, AXI4-Lite register access, oscillator ticks as enables
package ebp_pkg;

    // register indexes; byte address is four times the index
    localparam logic [9:0] IDX_CTRL = 10'h01c;
    localparam logic [9:0] IDX_DATA = 10'h01d;
    localparam logic [9:0] IDX_ADDR_LO = 10'h01e;
    localparam logic [9:0] IDX_ADDR_HI = 10'h01f;
    localparam logic [9:0] DATA_SPACE_OFS = 10'h020;
    localparam logic [9:0] IDX_BITOP = 10'h080;
    localparam logic [7:0] BIT_IO_LIMIT = 8'h20;

    // control register fields
    localparam int CTRL_RD = 0;
    localparam int CTRL_PE = 1;
    localparam int CTRL_ARM = 2;
    localparam int CTRL_RIE = 3;
    localparam int CTRL_PM_LO = 4;
    localparam int CTRL_PM_HI = 5;

    // bit operation register fields
    localparam int BOP_BIT_LSB = 8;
    localparam int BOP_OP_LSB = 12;
    localparam logic [1:0] BOP_TEST = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_CLR = 2'h2;

    // cycle counts of the core clock
    localparam logic [2:0] READ_STALL = 3'h4;
    localparam logic [2:0] PROG_STALL = 3'h2;
    localparam logic [2:0] ARM_WINDOW = 3'h4;

    // programming times, counted in calibrated oscillator ticks
    localparam int TMR_W = 16;
    localparam int OSC_HZ_DEF = 8_000_000;
    localparam real ATOMIC_MS = 3.4;
    localparam real SPLIT_MS = 1.8;
    localparam int ATOMIC_TICKS_DEF = int'(ATOMIC_MS * 1.0e-3 * OSC_HZ_DEF);
    localparam int SPLIT_TICKS_DEF = int'(SPLIT_MS * 1.0e-3 * OSC_HZ_DEF);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    typedef enum logic [1:0] {PM_ATOMIC = 2'h0, PM_ERASE = 2'h1, PM_WRITE = 2'h2, PM_RSVD = 2'h3} ebp_mode_t;
    typedef enum logic {FSM_IDLE, FSM_BUSY} ebp_fsm_t;
    typedef enum logic [2:0] {RS_CTRL, RS_DATA, RS_ALO, RS_AHI, RS_BITOP, RS_NONE} ebp_rsel_t;

    typedef struct packed {
        ebp_fsm_t fsm;
        logic [1:0] mode;
        logic [1:0] op;
        logic irq_en;
        logic [2:0] arm;
        logic [2:0] stall;
        logic [TMR_W-1:0] tmr;
        logic [8:0] idx;
        logic [7:0] data;
        logic [8:0] pidx;
        logic [7:0] pdata;
        logic [7:0] bsel;
        logic aw_ok;
        logic [9:0] aw_idx;
        logic w_ok;
        logic [7:0] w_data;
        logic [15:0] w_hi;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ebp_state_t;

    localparam ebp_state_t ST_RESET = '0;

endpackage

// >>> ebp_top.sv
// byte-organised nonvolatile store with arm/strobe programming, AXI4-Lite registers
// assumes: osc_tick is a one-cycle enable from the calibrated oscillator divider,
// global_irq_en mirrors the core's global interrupt enable
//
// What this block does
// RULE1 - byte store of 128, 256 or 512 bytes
// RULE2 - read strobe stalls core four cycles
// RULE3 - program strobe stalls core two cycles
// RULE4 - mode zero strobe does erase plus write
// RULE5 - mode one strobe erases addressed byte
// RULE6 - mode two strobe writes addressed byte
// RULE7 - strobe bit reads set while busy
// RULE8 - busy store rejects reads and programs
// RULE9 - software erases before write-only operation
// RULE10 - reset lets running programming finish
// RULE11 - programming timed by oscillator ticks
// RULE12 - index, data, control in I/O space
// RULE13 - registers also appear at N plus 0x20
// RULE14 - low I/O registers allow bit operations
// RULE15 - bit set/clear touches only one bit
// RULE16 - times 3.4 ms, 1.8 ms; mode three reserved
// RULE17 - arm clears after four cycles, gates strobe
// RULE18 - read strobe loads byte immediately
// RULE19 - ready interrupt level while idle, enabled
// RULE20 - busy ignores mode and index writes
// RULE21 - reserved mode strobe starts nothing
// RULE22 - arm window counts from arm write
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module ebp_top import ebp_pkg::*; #(
    parameter int DEPTH = 512,
    parameter logic [TMR_W-1:0] ATOMIC_TICKS = TMR_W'(ATOMIC_TICKS_DEF),
    parameter logic [TMR_W-1:0] SPLIT_TICKS = TMR_W'(SPLIT_TICKS_DEF)
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core side
    input wire logic osc_tick,
    input wire logic global_irq_en,
    output logic core_stall,
    output logic ready_irq
);

    localparam int AW = $clog2(DEPTH);

    ebp_state_t st_r, st_nxt;
    logic [7:0] mem [DEPTH]; // RULE1
    logic [7:0] rb [4];
    logic commit, fire, rd_go, pe_go, pe_try, arm_go;
    logic [7:0] mem_cur, mem_new;

    function automatic ebp_rsel_t decode(input logic [9:0] ix);
        if (ix == IDX_BITOP) begin
            return RS_BITOP;
        end
        if (ix >= DATA_SPACE_OFS && ix < DATA_SPACE_OFS + 10'h020) begin
            ix = ix - DATA_SPACE_OFS; // RULE13
        end
        case (ix)
            IDX_CTRL: return RS_CTRL; // RULE12
            IDX_DATA: return RS_DATA;
            IDX_ADDR_LO: return RS_ALO;
            IDX_ADDR_HI: return RS_AHI;
            default: return RS_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register read view

    always_comb begin
        rb[0] = {2'h0, st_r.mode, st_r.irq_en, st_r.arm != 3'h0, st_r.fsm == FSM_BUSY, 1'b0}; // RULE7
        rb[1] = st_r.data;
        rb[2] = st_r.idx[7:0];
        rb[3] = {7'h00, st_r.idx[8]};
    end

    assign mem_cur = mem[st_r.pidx[AW-1:0]];
    assign commit = st_r.fsm == FSM_BUSY && osc_tick && st_r.tmr == TMR_W'(1); // RULE11

    always_comb begin
        case (ebp_mode_t'(st_r.op))
            PM_ATOMIC: mem_new = st_r.pdata; // RULE4
            PM_ERASE: mem_new = ERASED_BYTE; // RULE5
            default: mem_new = mem_cur & st_r.pdata; // RULE6
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        ebp_state_t n;
        ebp_rsel_t rs;
        logic [7:0] wb, wm, rv;
        logic [2:0] bit_no;
        n = st_r;
        rs = RS_NONE;
        wb = st_r.w_data;
        wm = 8'h00;
        rv = 8'h00;
        bit_no = 3'h0;
        rd_go = 1'b0;
        pe_go = 1'b0;
        pe_try = 1'b0;
        arm_go = 1'b0;
        fire = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
        n.arm = (st_r.arm != 3'h0) ? st_r.arm - 3'h1 : 3'h0; // RULE17
        n.stall = (st_r.stall != 3'h0) ? st_r.stall - 3'h1 : 3'h0;
        if (st_r.fsm == FSM_BUSY && osc_tick) begin
            n.tmr = st_r.tmr - TMR_W'(1);
            if (commit) begin
                n.fsm = FSM_IDLE;
            end
        end
        // axi write channels are taken independently
        if (s_axi_awvalid && !st_r.aw_ok) begin
            n.aw_ok = 1'b1;
            n.aw_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && !st_r.w_ok) begin
            n.w_ok = 1'b1;
            n.w_data = s_axi_wdata[7:0];
            n.w_hi = s_axi_wdata[BOP_OP_LSB+3:0+BOP_OP_LSB-12];
            n.w_lane = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (fire) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            rs = decode(st_r.aw_idx);
            wm = st_r.w_lane ? 8'hff : 8'h00;
            if (rs == RS_BITOP) begin
                rs = RS_NONE;
                wm = 8'h00;
                if (st_r.w_lane && st_r.w_data < BIT_IO_LIMIT) begin // RULE14
                    bit_no = st_r.w_hi[BOP_BIT_LSB+2:BOP_BIT_LSB];
                    n.bsel = {bit_no, st_r.w_data[4:0]};
                    rs = decode({5'h00, st_r.w_data[4:0]});
                    wm = (st_r.w_hi[BOP_OP_LSB+1:BOP_OP_LSB] == BOP_TEST) ? 8'h00 : 8'h01 << bit_no; // RULE15
                    wb = (st_r.w_hi[BOP_OP_LSB+1:BOP_OP_LSB] == BOP_SET) ? 8'hff : 8'h00;
                end
            end else if (rs == RS_NONE) begin
                n.bresp = RESP_SLVERR;
            end
            case (rs)
                RS_CTRL: begin
                    if (wm[CTRL_RIE]) begin
                        n.irq_en = wb[CTRL_RIE];
                    end
                    if (st_r.fsm == FSM_IDLE) begin // RULE20
                        if (wm[CTRL_PM_LO]) begin
                            n.mode[0] = wb[CTRL_PM_LO];
                        end
                        if (wm[CTRL_PM_HI]) begin
                            n.mode[1] = wb[CTRL_PM_HI];
                        end
                    end
                    if (wm[CTRL_ARM] && wb[CTRL_ARM]) begin
                        arm_go = 1'b1;
                        n.arm = ARM_WINDOW; // RULE22
                    end
                    if (wm[CTRL_PE] && wb[CTRL_PE]) begin
                        pe_try = 1'b1;
                        // no arm, busy store or reserved mode: strobe is dropped
                        if (st_r.arm != 3'h0 && st_r.fsm == FSM_IDLE && st_r.mode != PM_RSVD) begin // RULE17 RULE8 RULE21
                            pe_go = 1'b1;
                            n.fsm = FSM_BUSY;
                            n.op = st_r.mode;
                            n.tmr = (st_r.mode == PM_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS; // RULE16
                            n.pidx = st_r.idx;
                            n.pdata = st_r.data;
                            n.stall = PROG_STALL; // RULE3
                        end
                    end
                    if (wm[CTRL_RD] && wb[CTRL_RD] && st_r.fsm == FSM_IDLE) begin // RULE8
                        rd_go = 1'b1;
                        n.data = mem[st_r.idx[AW-1:0]]; // RULE18
                        n.stall = READ_STALL; // RULE2
                    end
                end
                RS_DATA: n.data = (st_r.data & ~wm) | (wb & wm);
                RS_ALO: begin
                    if (st_r.fsm == FSM_IDLE) begin // RULE20
                        n.idx[7:0] = (st_r.idx[7:0] & ~wm) | (wb & wm);
                    end
                end
                RS_AHI: begin
                    if (st_r.fsm == FSM_IDLE && wm[0]) begin
                        n.idx[8] = (AW > 8) ? wb[0] : 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // axi read: answered one cycle after the address is taken
        if (s_axi_rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_r.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            rs = decode(s_axi_araddr[11:2]);
            case (rs)
                RS_CTRL: rv = rb[0];
                RS_DATA: rv = rb[1];
                RS_ALO: rv = rb[2];
                RS_AHI: rv = rb[3];
                RS_BITOP: rv = {7'h00, rb[st_r.bsel[1:0]][st_r.bsel[7:5]] & (st_r.bsel[4:2] == 3'h7)};
                default: n.rresp = RESP_SLVERR;
            endcase
            n.rdata = {24'h000000, rv};
        end
        if (!aresetn) begin
            n = ST_RESET;
            if (st_r.fsm == FSM_BUSY && !commit) begin // RULE10
                n.fsm = FSM_BUSY;
                n.mode = st_r.mode;
                n.op = st_r.op;
                n.tmr = osc_tick ? st_r.tmr - TMR_W'(1) : st_r.tmr;
                n.pidx = st_r.pidx;
                n.pdata = st_r.pdata;
            end
        end
        st_nxt = n;
    end

    always_ff @(posedge aclk) begin
        st_r <= st_nxt;
    end

    // storage has no reset: its content is nonvolatile
    always_ff @(posedge aclk) begin
        if (commit) begin
            mem[st_r.pidx[AW-1:0]] <= mem_new; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign s_axi_awready = !st_r.aw_ok;
    assign s_axi_wready = !st_r.w_ok;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign core_stall = st_r.stall != 3'h0;
    assign ready_irq = st_r.irq_en && global_irq_en && st_r.fsm == FSM_IDLE; // RULE19

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_read_stall_four: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        rd_go |=> core_stall [*4] ##1 !core_stall) else $error("read stall not four cycles");
    a_prog_stall_two: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        pe_go |=> core_stall [*2] ##1 !core_stall) else $error("program stall not two cycles");
    a_strobe_reads_busy: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        pe_go |=> rb[0][CTRL_PE] && !ready_irq) else $error("strobe bit not set after start");
    a_busy_no_read: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        (st_r.fsm == FSM_BUSY) |-> !rd_go && !pe_go) else $error("access taken while busy");
    a_arm_four_cycles: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        arm_go |=> (st_r.arm != 3'h0) [*4]) else $error("arm window shorter than four");
    a_no_arm_no_start: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        (pe_try && st_r.arm == 3'h0 && st_r.fsm == FSM_IDLE) |=> st_r.fsm == FSM_IDLE)
        else $error("strobe without arm started work");
    a_rsvd_mode_idle: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
        (pe_try && st_r.mode == PM_RSVD && st_r.fsm == FSM_IDLE) |=> st_r.fsm == FSM_IDLE)
        else $error("reserved mode started work");
    a_busy_index_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
        (st_r.fsm == FSM_BUSY) |=> $stable(st_r.idx) && $stable(st_r.mode)) else $error("index or mode changed");
    a_reset_keeps_prog: assert property (@(posedge aclk) // RULE10
        (!aresetn && st_r.fsm == FSM_BUSY && !commit) |=> st_r.fsm == FSM_BUSY) else $error("reset aborted programming");
    a_commit_ends_busy: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
        commit |=> st_r.fsm == FSM_IDLE && rb[0][CTRL_PE] == 1'b0) else $error("busy not ended at commit");
    a_start_timer_load: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
        pe_go |=> st_r.tmr == ((st_r.op == PM_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS)) else $error("wrong programming time");
    a_read_data_now: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
        rd_go |=> st_r.data == mem[$past(st_r.idx[AW-1:0])]) else $error("read data not loaded");

    c_read: cover property (@(posedge aclk) disable iff (!aresetn) rd_go);
    c_atomic: cover property (@(posedge aclk) disable iff (!aresetn) pe_go && st_r.mode == PM_ATOMIC);
    c_erase_done: cover property (@(posedge aclk) disable iff (!aresetn) commit && st_r.op == PM_ERASE);
    c_reset_busy: cover property (@(posedge aclk) !aresetn && st_r.fsm == FSM_BUSY);

endmodule

// >>> ebp_osc_model.sv
// stand-in for the calibrated oscillator divider: one-cycle tick every DIV core cycles
// assumes: sampled by the byte programmer on the same aclk
`timescale 1ns/10ps
module ebp_osc_model #(
    parameter int DIV = 4
) (
    // clock
    input wire logic aclk,
    // tick out
    output logic osc_tick
);
    int cnt = 0;
    // free running, so a core reset does not disturb the programming pace
    always_ff @(posedge aclk) begin
        cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
        osc_tick <= (cnt == DIV - 1);
    end
endmodule

// >>> tb_ebp_top.sv
// directed testbench of the byte programmer over AXI4-Lite
// assumes: ebp_pkg and ebp_top compiled first, oscillator model gives osc_tick
`timescale 1ns/10ps
module tb_ebp_top import ebp_pkg::*;;
    localparam int DIV = 4;
    localparam int AT = 20;
    localparam int ST = 10;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, gie = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    // byte lanes offered by the next write; lane 0 off must leave the register alone
    logic [3:0] lane = 4'h1;
    logic awready, wready, bvalid, arready, rvalid, core_stall, ready_irq, osc_tick;
    logic [1:0] bresp, rresp, last_b, last_r;
    int err_total = 0, samples_checked = 0, cyc = 0, stall_n = 0, low_n = 0, s0, d;

    ebp_osc_model #(.DIV(DIV)) osc (.aclk(aclk), .osc_tick(osc_tick));
    ebp_top #(.DEPTH(512), .ATOMIC_TICKS(16'(AT)), .SPLIT_TICKS(16'(ST))) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_tick(osc_tick),
        .global_irq_en(gie), .core_stall(core_stall), .ready_irq(ready_irq));

    initial begin
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (core_stall === 1'b1) stall_n <= stall_n + 1;
        if (gie === 1'b1 && ready_irq === 1'b0) low_n <= low_n + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks made %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // callers enter just after a rising edge; ready levels read here are pre-edge values
    task automatic wr(logic [9:0] idx, logic [31:0] v);
        awaddr <= {idx, 2'h0};
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= lane;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        last_b = bresp;
    endtask
    task automatic rd(logic [9:0] idx, output logic [31:0] v);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        last_r = rresp;
    endtask
    task automatic rchk(string nm, logic [9:0] idx, logic [31:0] exp);
        logic [31:0] v;
        rd(idx, v);
        chk(nm, v, exp);
    endtask
    task automatic wait_idle;
        logic [31:0] v;
        v = 32'h2;
        while (v[CTRL_PE] !== 1'b0) rd(IDX_CTRL, v);
    endtask
    // mode, then arm, then strobe back to back; ready interrupt enable kept set
    task automatic prog(logic [1:0] m, logic [8:0] a, logic [7:0] v);
        wr(IDX_ADDR_LO, {24'h0, a[7:0]});
        wr(IDX_ADDR_HI, {31'h0, a[8]});
        wr(IDX_DATA, {24'h0, v});
        wr(IDX_CTRL, {26'h0, m, 4'h8});
        wr(IDX_CTRL, {26'h0, m, 4'hc});
        wr(IDX_CTRL, {26'h0, m, 4'ha});
    endtask
    task automatic fetch(logic [8:0] a, logic [7:0] exp);
        wr(IDX_ADDR_LO, {24'h0, a[7:0]});
        wr(IDX_ADDR_HI, {31'h0, a[8]});
        s0 = stall_n;
        wr(IDX_CTRL, 32'h1);
        rchk("fetched byte", IDX_DATA, {24'h0, exp});
        repeat (4) @(posedge aclk);
        chk("read stall", 32'(stall_n - s0), 32'h4);
    endtask
    function automatic logic [31:0] bop(logic [1:0] op, int b, logic [7:0] i);
        return {18'h0, op, 1'b0, 3'(b), i};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk("ctrl reset", IDX_CTRL, 32'h0);
        rchk("index reset", IDX_ADDR_LO, 32'h0);
        rchk("unmapped read", 10'h040, 32'h0);
        chk("unmapped rresp", last_r, RESP_SLVERR);
        wr(10'h040, 32'h1);
        chk("unmapped bresp", last_b, RESP_SLVERR);
        $display("test reset done");

        s0 = stall_n;
        prog(PM_ATOMIC, 9'h105, 8'ha5);
        rchk("busy ctrl", IDX_CTRL, 32'ha);
        wr(IDX_ADDR_LO, 32'h7);
        rchk("index while busy", IDX_ADDR_LO, 32'h5);
        wr(IDX_CTRL, 32'h39);
        rchk("mode while busy", IDX_CTRL, 32'ha);
        rchk("data while busy", IDX_DATA, 32'ha5);
        chk("program stall", 32'(stall_n - s0), 32'h2);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk("busy after reset", IDX_CTRL, 32'h2);
        wait_idle();
        fetch(9'h105, 8'ha5);
        $display("test atomic done");

        wr(IDX_CTRL, 32'h8);
        gie <= 1'b1;
        s0 = low_n;
        prog(PM_ERASE, 9'h105, 8'h00);
        wait_idle();
        d = low_n - s0;
        chk("erase time", 32'(d >= (ST - 1) * DIV && d <= ST * DIV + 1), 32'h1);
        chk("ready irq", 32'(ready_irq), 32'h1);
        fetch(9'h105, ERASED_BYTE);
        prog(PM_WRITE, 9'h105, 8'h3c);
        wait_idle();
        fetch(9'h105, 8'h3c);
        prog(PM_WRITE, 9'h105, 8'hc3);
        wait_idle();
        fetch(9'h105, 8'h00);
        wr(IDX_CTRL, 32'h8);
        gie <= 1'b0;
        @(posedge aclk);
        @(posedge aclk);
        chk("irq masked", 32'(ready_irq), 32'h0);
        $display("test split done");

        wr(IDX_CTRL, 32'h2);
        rchk("strobe unarmed", IDX_CTRL, 32'h0);
        wr(IDX_CTRL, 32'h4);
        repeat (6) @(posedge aclk);
        rchk("arm expired", IDX_CTRL, 32'h0);
        wr(IDX_CTRL, 32'h2);
        rchk("strobe late", IDX_CTRL, 32'h0);
        prog(PM_RSVD, 9'h0, 8'h0);
        rchk("reserved mode", IDX_CTRL, 32'h38);
        $display("test refusal done");

        wr(IDX_ADDR_LO + DATA_SPACE_OFS, 32'h5a);
        rchk("alias index", IDX_ADDR_LO, 32'h5a);
        rchk("alias ctrl", IDX_CTRL + DATA_SPACE_OFS, 32'h38);
        lane = 4'h2;
        wr(IDX_DATA, 32'h77);
        lane = 4'h1;
        chk("lane off bresp", last_b, RESP_OKAY);
        rchk("lane off data", IDX_DATA, 32'h0);
        wr(IDX_CTRL, 32'h0);
        wr(IDX_BITOP, bop(BOP_SET, CTRL_RIE, IDX_CTRL[7:0]));
        rchk("bit set", IDX_CTRL, 32'h8);
        wr(IDX_BITOP, bop(BOP_CLR, CTRL_RIE, 8'h3c));
        rchk("bit op high io", IDX_CTRL, 32'h8);
        wr(IDX_BITOP, bop(BOP_TEST, CTRL_RIE, IDX_CTRL[7:0]));
        rchk("bit test", IDX_BITOP, 32'h1);
        wr(IDX_ADDR_LO, 32'h0);
        wr(IDX_ADDR_HI, 32'h0);
        wr(IDX_DATA, 32'h11);
        wr(IDX_BITOP, bop(BOP_SET, CTRL_ARM, IDX_CTRL[7:0]));
        wr(IDX_BITOP, bop(BOP_SET, CTRL_PE, IDX_CTRL[7:0]));
        rchk("bit program", IDX_CTRL, 32'ha);
        wait_idle();
        fetch(9'h000, 8'h11);
        $display("test bit access done");
        end_of_test();
    end
endmodule
